// ===== eoc_defines.svh
// Constants for the external oscillator control block: offsets, fields, resets.
// Assumes inclusion by bare name from any file of the block.
`ifndef EOC_DEFINES_SVH
`define EOC_DEFINES_SVH
`define EOC_ADDR_W 8
`define EOC_OFF_CTRL 8'h00
`define EOC_OFF_INT_STAT 8'h04
`define EOC_OFF_INT_EN 8'h08
`define EOC_OFF_INT_CLR 8'h0C
`define EOC_OFF_PIN_STAT 8'h10
`define EOC_CTRL_VALID_BIT 7
`define EOC_CTRL_MODE_MSB 6
`define EOC_CTRL_MODE_LSB 4
`define EOC_CTRL_DFS_MSB 2
`define EOC_CTRL_DFS_LSB 0
`define EOC_CTRL_RESET 6'h00
`define EOC_INT_W 2
`define EOC_INT_RESET 2'h0
`define EOC_INT_VALID_UP 0
`define EOC_INT_VALID_DOWN 1
`define EOC_PIN_IN_BIT 0
`define EOC_PIN_OUT_BIT 1
`define EOC_EXT_DIV 8
`define EOC_RESP_OKAY 2'h0
`define EOC_RESP_SLVERR 2'h2
`endif

// ===== eoc_pkg.sv
// Types shared by the external oscillator control block.
// Assumes nothing of its surroundings.
package eoc_pkg;

  typedef enum logic [2:0] {
    EOC_MODE_OFF,
    EOC_MODE_CMOS,
    EOC_MODE_CMOS_DIV2,
    EOC_MODE_RC,
    EOC_MODE_CAP,
    EOC_MODE_XTAL
  } eoc_mode_e;

  typedef struct packed {
    logic [2:0] mode_sel;
    logic [2:0] drive_frequency_select;
  } eoc_ctrl_s;

  typedef struct packed {
    logic osc_in_claim;
    logic osc_out_claim;
  } eoc_pins_s;

  function automatic eoc_mode_e eoc_decode(input logic [2:0] f);
    eoc_mode_e m;
    m = EOC_MODE_OFF;
    unique casez (f)
      3'b00?: m = EOC_MODE_OFF;
      3'b010: m = EOC_MODE_CMOS;
      3'b011: m = EOC_MODE_CMOS_DIV2;
      3'b100: m = EOC_MODE_RC;
      3'b101: m = EOC_MODE_CAP;
      3'b11?: m = EOC_MODE_XTAL;
    endcase
    return m;
  endfunction

endpackage

// ===== eoc_div8.sv
// Synchroniser and divider turning the raw oscillator pin into a tick.
// Assumes osc_raw is asynchronous to aclk and no faster than half the aclk rate.
`timescale 1ns/1ns
`include "eoc_defines.svh"
module eoc_div8 #(
  parameter int DIV = `EOC_EXT_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic halve,
  input wire logic osc_raw,
  output logic tick
);
  import eoc_pkg::*;

  localparam int CW = $clog2(DIV);

  if (DIV < 2 || (1 << CW) != DIV) begin : g_bad_div
    $error("DIV must be a power of two of at least two.");
  end

  logic s1_reg, s2_reg, s3_reg;
  logic half_reg, half_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic tick_next;
  logic rise;

  // ------------------------------------------------------------
  // Edge counting
  // ------------------------------------------------------------
  // The two-stage capture costs up to one cycle of phase, which keeps
  // the tick within half a system cycle of jitter around its mean.
  always_comb begin
    rise = s2_reg && !s3_reg;
    half_next = half_reg;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!enable) begin
      half_next = 1'b0;
      cnt_next = '0;
    end else if (rise) begin
      half_next = !half_reg;
      if (!halve || half_reg) begin
        cnt_next = cnt_reg + 1'b1;
        tick_next = (cnt_reg == CW'(DIV - 1));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      half_reg <= 1'b0;
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      s1_reg <= osc_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      half_reg <= half_next;
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end

endmodule // eoc_div8

// ===== eoc_top.sv
// External oscillator control: mode register, pin claims, crystal-valid flag,
// divided peripheral tick and interrupt, behind an AXI4-Lite slave.
// Assumes the analog amplifier and pad logic sit outside and use the outputs.
//
// Contract
// - Crystal mode claims input and output pins.
// - Other active modes claim output pin only.
// - Offer oscillator divided by eight tick; EOC_MODE_CMOS_DIV2 divides by sixteen.
// - Tick synchronised, jitter within half cycle.
// - Never switch system clock before valid.
// - Mode field decodes into six modes.
`timescale 1ns/1ns
`include "eoc_defines.svh"
module eoc_top #(
  parameter int EXT_DIV = `EOC_EXT_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`EOC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EOC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_clk_pin,
  input wire logic amp_stable_pin,
  output eoc_pkg::eoc_pins_s pin_claim,
  output logic osc_drive_enable,
  output logic [2:0] osc_drive_freq,
  output eoc_pkg::eoc_mode_e osc_mode,
  output logic crystal_valid_flag,
  output logic ext_div8_tick,
  output logic irq
);
  import eoc_pkg::*;

  // ------------------------------------------------------------
  // Register bus state
  // ------------------------------------------------------------
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [`EOC_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next;
  logic wr_fire;

  // ------------------------------------------------------------
  // Control and status state
  // ------------------------------------------------------------
  eoc_ctrl_s ctrl_reg, ctrl_next;
  logic [`EOC_INT_W-1:0] int_stat_reg, int_stat_next;
  logic [`EOC_INT_W-1:0] int_en_reg, int_en_next;
  logic [`EOC_INT_W-1:0] int_set, int_clr;
  logic amp_s1_reg, amp_s2_reg;
  logic valid_next;
  eoc_pins_s pins_next;
  eoc_mode_e mode_dec;
  logic irq_next;

  always_comb begin
    wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_lane0_next = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      unique case (aw_addr_reg)
        `EOC_OFF_CTRL, `EOC_OFF_INT_EN, `EOC_OFF_INT_CLR: bresp_next = `EOC_RESP_OKAY;
        `EOC_OFF_INT_STAT, `EOC_OFF_PIN_STAT: bresp_next = `EOC_RESP_OKAY;
        default: bresp_next = `EOC_RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_have_next;
    wready_next = !w_have_next;
  end

  always_comb begin
    rvalid_next = s_axi_rvalid;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = 32'h0000_0000;
      rresp_next = `EOC_RESP_OKAY;
      unique case (s_axi_araddr)
        `EOC_OFF_CTRL: begin
          rdata_next[`EOC_CTRL_VALID_BIT] = crystal_valid_flag;
          rdata_next[`EOC_CTRL_MODE_MSB:`EOC_CTRL_MODE_LSB] = ctrl_reg.mode_sel;
          rdata_next[`EOC_CTRL_DFS_MSB:`EOC_CTRL_DFS_LSB] = ctrl_reg.drive_frequency_select;
        end
        `EOC_OFF_INT_STAT: rdata_next[`EOC_INT_W-1:0] = int_stat_reg;
        `EOC_OFF_INT_EN: rdata_next[`EOC_INT_W-1:0] = int_en_reg;
        `EOC_OFF_INT_CLR: rdata_next = 32'h0000_0000;
        `EOC_OFF_PIN_STAT: begin
          rdata_next[`EOC_PIN_IN_BIT] = pin_claim.osc_in_claim;
          rdata_next[`EOC_PIN_OUT_BIT] = pin_claim.osc_out_claim;
        end
        default: rresp_next = `EOC_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // ------------------------------------------------------------
  // Mode, pins, valid flag and interrupt
  // ------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    int_en_next = int_en_reg;
    int_clr = '0;
    if (wr_fire && w_lane0_reg) begin
      unique case (aw_addr_reg)
        `EOC_OFF_CTRL: begin
          // The valid bit and the reserved bit ignore writes.
          ctrl_next.mode_sel = w_data_reg[`EOC_CTRL_MODE_MSB:`EOC_CTRL_MODE_LSB];
          ctrl_next.drive_frequency_select = w_data_reg[`EOC_CTRL_DFS_MSB:`EOC_CTRL_DFS_LSB];
        end
        `EOC_OFF_INT_EN: int_en_next = w_data_reg[`EOC_INT_W-1:0];
        `EOC_OFF_INT_CLR: int_clr = w_data_reg[`EOC_INT_W-1:0];
        default: ;
      endcase
    end
    mode_dec = eoc_decode(ctrl_next.mode_sel);
    pins_next.osc_in_claim = (mode_dec == EOC_MODE_XTAL);
    pins_next.osc_out_claim = (mode_dec != EOC_MODE_OFF);
    valid_next = (mode_dec == EOC_MODE_XTAL) && amp_s2_reg;
    int_set = '0;
    int_set[`EOC_INT_VALID_UP] = valid_next && !crystal_valid_flag;
    int_set[`EOC_INT_VALID_DOWN] = !valid_next && crystal_valid_flag;
    // A new event outweighs a clear written in the same cycle.
    int_stat_next = (int_stat_reg & ~int_clr) | int_set;
    irq_next = |(int_stat_next & int_en_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EOC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `EOC_RESP_OKAY;
      ctrl_reg <= `EOC_CTRL_RESET;
      int_stat_reg <= `EOC_INT_RESET;
      int_en_reg <= `EOC_INT_RESET;
      amp_s1_reg <= 1'b0;
      amp_s2_reg <= 1'b0;
      pin_claim <= '0;
      osc_drive_enable <= 1'b0;
      osc_drive_freq <= 3'h0;
      osc_mode <= EOC_MODE_OFF;
      crystal_valid_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
      ctrl_reg <= ctrl_next;
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      amp_s1_reg <= amp_stable_pin;
      amp_s2_reg <= amp_s1_reg;
      pin_claim <= pins_next;
      osc_drive_enable <= (mode_dec != EOC_MODE_OFF);
      osc_drive_freq <= ctrl_next.drive_frequency_select;
      osc_mode <= mode_dec;
      crystal_valid_flag <= valid_next;
      irq <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // Peripheral tick
  // ------------------------------------------------------------
  // synchronised divided tick
  eoc_div8 #(
    .DIV(EXT_DIV)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(osc_drive_enable),
    .halve(osc_mode == EOC_MODE_CMOS_DIV2),
    .osc_raw(osc_clk_pin),
    .tick(ext_div8_tick)
  );

endmodule // eoc_top

// ===== eoc_osc_model.sv
// Behavioural far side: an oscillator source and its amplitude detector.
// Assumes the bench drives run and good; both outputs are asynchronous to aclk.
`timescale 1ns/1ns
module eoc_osc_model #(
  parameter int HALF_NS = 13
) (
  input wire logic run,
  input wire logic good,
  output logic osc_clk_pin,
  output logic amp_stable_pin
);
  initial osc_clk_pin = 1'b0;
  // slower than system
  // The source stands still low between runs rather than holding its last level.
  always begin
    #HALF_NS;
    osc_clk_pin = run ? ~osc_clk_pin : 1'b0;
  end
  always @(good) amp_stable_pin <= #57 good;
  initial amp_stable_pin = 1'b0;
endmodule // eoc_osc_model

// ===== eoc_monitor.sv
// Checker of the oscillator control ports, bound into the top module.
// Assumes one clock domain with a synchronous active low reset.
`timescale 1ns/1ns
module eoc_monitor #(
  parameter int EXT_DIV = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire eoc_pkg::eoc_pins_s pin_claim,
  input wire logic osc_drive_enable,
  input wire eoc_pkg::eoc_mode_e osc_mode,
  input wire logic crystal_valid_flag,
  input wire logic ext_div8_tick
);
  import eoc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_IN_CLAIM: assert property (pin_claim.osc_in_claim == (osc_mode == EOC_MODE_XTAL))
    else $error("input pin claim does not follow crystal mode");
  AST_OUT_CLAIM: assert property (pin_claim.osc_out_claim == (osc_mode != EOC_MODE_OFF))
    else $error("output pin claim does not follow active mode");
  AST_DRIVE_EN: assert property (osc_drive_enable == pin_claim.osc_out_claim)
    else $error("drive enable differs from output claim");
  AST_VALID_XTAL: assert property (crystal_valid_flag |-> osc_mode == EOC_MODE_XTAL)
    else $error("valid flag set outside crystal mode");
  AST_TICK_GAP: assert property (ext_div8_tick |=> !ext_div8_tick [*8])
    else $error("ticks closer than the division allows");
  AST_TICK_OFF: assert property ((osc_mode == EOC_MODE_OFF) [*4] |-> !ext_div8_tick)
    else $error("tick while oscillator off");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
endmodule // eoc_monitor
bind eoc_top eoc_monitor #(.EXT_DIV(EXT_DIV)) u_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_claim, .osc_drive_enable,
  .osc_mode, .crystal_valid_flag, .ext_div8_tick);

// ===== eoc_top_tb_top.sv
// Self-checking bench of the oscillator control block over AXI4-Lite.
// Assumes the partner model supplies the pin clock and detector level.
`timescale 1ns/1ns
module eoc_top_tb_top;
  import eoc_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bw = 0, arv = 0, rr = 0, run = 0, good = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, d, s = 32'h71BF;
  logic [1:0] br, rrs, r;
  logic awr, wr_r, bv, arr, rv, ocp, asp, vf, tk, irq, den;
  logic [2:0] dfr;
  logic [3:0] ws = 4'hF;
  eoc_pins_s pc;
  eoc_mode_e om;
  int n_errors = 0, checked = 0, ticks = 0, rises = 0, i, t0, r0, n, e;
  always #5 aclk = ~aclk;
  eoc_osc_model u_osc (.run(run), .good(good), .osc_clk_pin(ocp), .amp_stable_pin(asp));
  eoc_top #(.EXT_DIV(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bw), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .osc_clk_pin(ocp), .amp_stable_pin(asp), .pin_claim(pc), .osc_drive_enable(den),
    .osc_drive_freq(dfr), .osc_mode(om), .crystal_valid_flag(vf), .ext_div8_tick(tk),
    .irq(irq));
  always @(posedge aclk) if (tk === 1'b1) ticks++;
  always @(posedge ocp) rises++;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [2:0] dmode(input logic [2:0] f);
    if (f[2:1] == 2'h0) return 3'h0;
    if (f[2:1] == 2'h3) return 3'h5;
    return f - 3'h1;
  endfunction
  task automatic test_done();
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input int k);
    if (k >= 100) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k;
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bw <= 1'b1;
    for (k = 0; k < 100 && (awv || wv); k++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end
    lim(k);
    for (k = 0; k < 100 && !bv; k++) @(posedge aclk);
    lim(k);
    resp = br;
    bw <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    for (k = 0; k < 100 && arv; k++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    lim(k);
    for (k = 0; k < 100 && !rv; k++) @(posedge aclk);
    lim(k);
    v = rd_d;
    resp = rrs;
    rr <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tick_run(input logic [2:0] m, input int div);
    wr(8'h00, {25'h0, m, 4'h0}, r);
    repeat (8) @(posedge aclk);
    #1 t0 = ticks; r0 = rises;
    repeat (400) @(posedge aclk);
    #1 n = ticks - t0; e = div ? (rises - r0) / div : 0;
    chk(n + 1 >= e && n <= e + (div ? 1 : 0), 1);
  endtask
  task automatic wait_vf(input logic v);
    int k;
    for (k = 0; k < 100 && vf !== v; k++) @(posedge aclk);
    lim(k);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, 0);
      chk(r, 0);
    end
    rd(8'h40, d, r);
    chk({d[0], r}, 2);
    wr(8'h40, 1, r);
    chk(r, 2);
    for (i = 0; i < 8; i++) begin
      s = lfsr(s);
      wr(8'h00, {s[31:7], i[2:0], 1'b1, s[2:0]}, r);
      rd(8'h00, d, r);
      chk(d, {25'h0, i[2:0], 1'b0, s[2:0]});
      chk(om, dmode(i[2:0]));
      chk(pc, {i[2:1] == 2'h3, i[2:1] != 2'h0});
      chk({den, dfr}, {i[2:1] != 2'h0, s[2:0]});
      rd(8'h10, d, r);
      chk(d, {i[2:1] != 2'h0, i[2:1] == 2'h3});
    end
    ws <= 4'hE;
    wr(8'h00, 32'h0, r);
    chk(r, 0);
    ws <= 4'hF;
    rd(8'h00, d, r);
    chk(d, {25'h0, 3'h7, 1'b0, s[2:0]});
    run <= 1'b1;
    tick_run(3'h2, 8);
    tick_run(3'h3, 16);
    tick_run(3'h0, 0);
    wr(8'h08, 3, r);
    wr(8'h00, 32'h67, r);
    good <= 1'b1;
    wait_vf(1'b1);
    rd(8'h00, d, r);
    chk(d, 32'hE7);
    rd(8'h04, d, r);
    chk(irq, 1);
    chk(d, 32'h1);
    wr(8'h04, 3, r);
    chk(r, 0);
    wr(8'h0C, 1, r);
    rd(8'h04, d, r);
    chk(irq, 0);
    chk(d, 0);
    good <= 1'b0;
    wait_vf(1'b0);
    rd(8'h04, d, r);
    chk(irq, 1);
    chk(d, 32'h2);
    wr(8'h08, 0, r);
    chk(irq, 0);
    wr(8'h0C, 3, r);
    good <= 1'b1;
    wr(8'h00, 32'h47, r);
    repeat (20) @(posedge aclk);
    rd(8'h00, d, r);
    chk(vf, 0);
    chk(d, 32'h47);
    test_done();
  end
endmodule // eoc_top_tb_top
